// file: include/jtp_pkg.sv
// package for the test access port: tap states, instruction codes, sizes
// assumes a single core clock domain samples every port pin except trst_n
package jtp_pkg;
    typedef enum logic [3:0] {
        JTP_TLR   = 4'hF,
        JTP_RTI   = 4'hC,
        JTP_SELDR = 4'h7,
        JTP_CAPDR = 4'h6,
        JTP_SHDR  = 4'h2,
        JTP_EX1DR = 4'h1,
        JTP_PSDR  = 4'h3,
        JTP_EX2DR = 4'h0,
        JTP_UPDR  = 4'h5,
        JTP_SELIR = 4'h4,
        JTP_CAPIR = 4'hE,
        JTP_SHIR  = 4'hA,
        JTP_EX1IR = 4'h9,
        JTP_PSIR  = 4'hB,
        JTP_EX2IR = 4'h8,
        JTP_UPIR  = 4'hD
    } jtp_state_t;

    localparam int          JTP_IR_W      = 4;
    localparam int          JTP_BSR_LEN   = 8;
    localparam int          JTP_CFG_W     = 8;
    localparam int          JTP_FIFO_D    = 8;
    localparam int          JTP_TLR_TMS   = 5;
    localparam logic [3:0]  JTP_IR_BYPASS = 4'hF;
    localparam logic [3:0]  JTP_IR_SAMPLE = 4'h5;
    localparam logic [3:0]  JTP_IR_CONFIG = 4'h2;
    localparam logic [3:0]  JTP_IR_RST    = 4'hF;
    localparam logic [3:0]  JTP_IR_CAPT   = 4'h1;
    localparam logic [2:0]  JTP_BIT_LAST  = 3'h7;
endpackage : jtp_pkg

// file: core/jtp_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes one clock; full and empty come from an occupancy count
`timescale 1ns/10ps
module jtp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    always_comb begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
        end
        if (pop) begin
            rd_d = (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // data words carry no reset: only the count says what is valid
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : jtp_fifo

// file: core/jtp_tap.sv
// test access port with boundary sample and configuration download
// assumes tck is much slower than ref_clk (edges found by sampling)
// Summary of operation
// [RULE1] four port pins tck, tms, tdi, tdo plus optional active-low reset.
// [RULE2] tdi is captured on each rising tck edge.
// [RULE3] tdo takes the next serial bit on each falling tck edge.
// [RULE4] tdo is not driven unless data is being shifted out.
// [RULE5] tms is sampled on rising tck and moves the tap state that edge.
// [RULE6] trst_n low resets the scan logic at once, without a clock.
// [RULE7] all user pins are released to high impedance during download.
// [RULE8] port instructions override every other configuration mode.
// [RULE9] a download start aborts any passive_serial load in progress.
// [RULE10] the cable side keeps trst_n high throughout a download.
// [RULE11] an unused port has tdi and tms high, tck and trst_n low.
// [RULE12] bypass passes tdi to tdo through one register bit.
// [RULE13] config_error_status_n goes low on an error during download.
// [RULE14] config_complete goes high when a download ends well.
// [RULE15] chip_wide_clear and chip_wide_output_enable never touch the tap.
// [RULE16] standard sixteen-state tap; five tms-high edges reach reset.
`timescale 1ns/10ps
module jtp_tap #(
    parameter int BSR_LEN = jtp_pkg::JTP_BSR_LEN,
    parameter int CFG_W   = jtp_pkg::JTP_CFG_W,
    parameter int FIFO_D  = jtp_pkg::JTP_FIFO_D
) (
    // clock, reset, enable
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // test port pins
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic               trst_n,
    output logic                    tdo_o,
    output logic                    tdo_oe,
    // user pins and chip-wide controls
    input  wire logic [BSR_LEN-1:0] user_pin_in,
    input  wire logic               chip_wide_clear,
    input  wire logic               chip_wide_output_enable,
    output logic                    user_io_oe,
    output logic                    user_clear_n,
    // configuration engine side
    input  wire logic               passive_serial_busy,
    input  wire logic               cfg_load_done,
    input  wire logic               cfg_load_err,
    output logic                    passive_serial_abort,
    output logic                    cfg_valid,
    input  wire logic               cfg_ready,
    output logic [CFG_W-1:0]        cfg_data,
    // status pins
    output logic                    config_complete,
    output logic                    config_error_status_n
);
    // synchronised pin bundle: tck, tms, tdi, clear, oe, then user pins
    localparam int NS = BSR_LEN + 5;
    localparam int BW = $clog2(CFG_W);
    // idle levels of the pins, so no false tck edge follows reset
    localparam logic [NS-1:0] SYNC_RST = {{BSR_LEN{1'b0}}, 5'h1E};

    logic [NS-1:0]              pin_raw;
    logic [NS-1:0]              pin_sync;
    logic                       tck_s3_q;
    logic                       tck_rise;
    logic                       tck_fall;
    logic                       tms_s;
    logic                       tdi_s;
    logic                       clr_s;
    logic                       oe_s;
    logic [BSR_LEN-1:0]         pin_s;
    logic                       tap_arst;

    // tap group
    jtp_pkg::jtp_state_t        st_q, st_d, st_nxt;
    logic [jtp_pkg::JTP_IR_W-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;
    logic [BSR_LEN-1:0]         bsr_q, bsr_d;
    logic                       byp_q, byp_d;
    logic [CFG_W-1:0]           cfg_sh_q, cfg_sh_d;
    logic [BW-1:0]              bit_q, bit_d;
    logic                       push_q, push_d;
    logic [CFG_W-1:0]           push_data_q, push_data_d;
    logic                       tdo_q, tdo_d;
    logic                       oe_q, oe_d;
    logic [2:0]                 ones_q, ones_d;

    // status group
    logic                       io_oe_q, io_oe_d;
    logic                       clr_n_q, clr_n_d;
    logic                       abort_q, abort_d;
    logic                       complete_q, complete_d;
    logic                       err_n_q, err_n_d;
    logic                       cv_q, cv_d;
    logic [CFG_W-1:0]           cd_q, cd_d;

    logic                       is_cfg;
    logic                       is_smp;
    logic                       act;
    logic                       start;
    logic                       f_valid;
    logic [CFG_W-1:0]           f_data;
    logic                       out_rdy;

    // every pin but trst_n crosses two flops before use [RULE1]
    assign pin_raw = {user_pin_in, chip_wide_output_enable,
                      chip_wide_clear, tdi, tms, tck};

    for (genvar i = 0; i < NS; i++) begin : g_sync
        logic s1_q;
        logic s2_q;
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1_q <= SYNC_RST[i];
                s2_q <= SYNC_RST[i];
            end else if (ce) begin
                s1_q <= pin_raw[i];
                s2_q <= s1_q;
            end
        end
        assign pin_sync[i] = s2_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tck_s3_q <= 1'b0;
        end else if (ce) begin
            tck_s3_q <= pin_sync[0];
        end
    end

    assign tck_rise = pin_sync[0] & ~tck_s3_q;
    assign tck_fall = ~pin_sync[0] & tck_s3_q;
    assign tms_s    = pin_sync[1];
    assign tdi_s    = pin_sync[2];
    assign clr_s    = pin_sync[3];
    assign oe_s     = pin_sync[4];
    assign pin_s    = pin_sync[NS-1:5];

    // raw trst_n acts at once; release is harmless while tck idles [RULE6]
    assign tap_arst = rst | ~trst_n;

    assign is_cfg = (ir_q == jtp_pkg::JTP_IR_CONFIG);
    assign is_smp = (ir_q == jtp_pkg::JTP_IR_SAMPLE);
    // port download wins over any other mode, no handshake [RULE8]
    assign act    = is_cfg & ~complete_q;
    assign start  = ce & tck_rise & (st_q == jtp_pkg::JTP_UPIR)
                    & (ir_sh_q == jtp_pkg::JTP_IR_CONFIG);

    // standard sixteen-state walk, all codes legal [RULE16]
    always_comb begin
        st_nxt = st_q;
        unique case (st_q)
            jtp_pkg::JTP_TLR:   st_nxt = tms_s ? jtp_pkg::JTP_TLR
                                               : jtp_pkg::JTP_RTI;
            jtp_pkg::JTP_RTI:   st_nxt = tms_s ? jtp_pkg::JTP_SELDR
                                               : jtp_pkg::JTP_RTI;
            jtp_pkg::JTP_SELDR: st_nxt = tms_s ? jtp_pkg::JTP_SELIR
                                               : jtp_pkg::JTP_CAPDR;
            jtp_pkg::JTP_CAPDR: st_nxt = tms_s ? jtp_pkg::JTP_EX1DR
                                               : jtp_pkg::JTP_SHDR;
            jtp_pkg::JTP_SHDR:  st_nxt = tms_s ? jtp_pkg::JTP_EX1DR
                                               : jtp_pkg::JTP_SHDR;
            jtp_pkg::JTP_EX1DR: st_nxt = tms_s ? jtp_pkg::JTP_UPDR
                                               : jtp_pkg::JTP_PSDR;
            jtp_pkg::JTP_PSDR:  st_nxt = tms_s ? jtp_pkg::JTP_EX2DR
                                               : jtp_pkg::JTP_PSDR;
            jtp_pkg::JTP_EX2DR: st_nxt = tms_s ? jtp_pkg::JTP_UPDR
                                               : jtp_pkg::JTP_SHDR;
            jtp_pkg::JTP_UPDR:  st_nxt = tms_s ? jtp_pkg::JTP_SELDR
                                               : jtp_pkg::JTP_RTI;
            jtp_pkg::JTP_SELIR: st_nxt = tms_s ? jtp_pkg::JTP_TLR
                                               : jtp_pkg::JTP_CAPIR;
            jtp_pkg::JTP_CAPIR: st_nxt = tms_s ? jtp_pkg::JTP_EX1IR
                                               : jtp_pkg::JTP_SHIR;
            jtp_pkg::JTP_SHIR:  st_nxt = tms_s ? jtp_pkg::JTP_EX1IR
                                               : jtp_pkg::JTP_SHIR;
            jtp_pkg::JTP_EX1IR: st_nxt = tms_s ? jtp_pkg::JTP_UPIR
                                               : jtp_pkg::JTP_PSIR;
            jtp_pkg::JTP_PSIR:  st_nxt = tms_s ? jtp_pkg::JTP_EX2IR
                                               : jtp_pkg::JTP_PSIR;
            jtp_pkg::JTP_EX2IR: st_nxt = tms_s ? jtp_pkg::JTP_UPIR
                                               : jtp_pkg::JTP_SHIR;
            jtp_pkg::JTP_UPIR:  st_nxt = tms_s ? jtp_pkg::JTP_SELDR
                                               : jtp_pkg::JTP_RTI;
        endcase
    end

    // chip_wide_* are never read by the tap group [RULE15]
    always_comb begin
        st_d        = st_q;
        ir_d        = ir_q;
        ir_sh_d     = ir_sh_q;
        bsr_d       = bsr_q;
        byp_d       = byp_q;
        cfg_sh_d    = cfg_sh_q;
        bit_d       = bit_q;
        push_d      = 1'b0;
        push_data_d = push_data_q;
        tdo_d       = tdo_q;
        oe_d        = oe_q;
        ones_d      = ones_q;
        if (tck_rise) begin
            st_d = st_nxt; // [RULE5]
            if (!tms_s) begin
                ones_d = 3'h0;
            end else if (ones_q != 3'(jtp_pkg::JTP_TLR_TMS)) begin
                ones_d = ones_q + 3'h1;
            end
            unique case (st_q)
                jtp_pkg::JTP_TLR: begin
                    ir_d = jtp_pkg::JTP_IR_RST;
                end
                jtp_pkg::JTP_CAPIR: begin
                    ir_sh_d = jtp_pkg::JTP_IR_CAPT;
                end
                jtp_pkg::JTP_SHIR: begin
                    ir_sh_d = {tdi_s, ir_sh_q[jtp_pkg::JTP_IR_W-1:1]}; // [RULE2]
                end
                jtp_pkg::JTP_UPIR: begin
                    ir_d = ir_sh_q;
                end
                jtp_pkg::JTP_CAPDR: begin
                    byp_d = 1'b0;
                    bit_d = '0;
                    if (is_smp) begin
                        bsr_d = pin_s;
                    end
                end
                jtp_pkg::JTP_SHDR: begin
                    byp_d = tdi_s; // [RULE12]
                    if (is_smp) begin
                        bsr_d = {tdi_s, bsr_q[BSR_LEN-1:1]};
                    end
                    if (is_cfg) begin
                        cfg_sh_d = {tdi_s, cfg_sh_q[CFG_W-1:1]}; // [RULE2]
                        bit_d    = bit_q + BW'(1);
                        if (bit_q == BW'(CFG_W-1)) begin
                            push_d      = 1'b1;
                            push_data_d = {tdi_s, cfg_sh_q[CFG_W-1:1]};
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (tck_fall) begin
            if (st_q == jtp_pkg::JTP_SHIR) begin
                tdo_d = ir_sh_q[0]; // [RULE3]
                oe_d  = 1'b1;
            end else if (st_q == jtp_pkg::JTP_SHDR) begin
                tdo_d = is_smp ? bsr_q[0] : (is_cfg ? cfg_sh_q[0] : byp_q);
                oe_d  = 1'b1;
            end else begin
                oe_d  = 1'b0; // [RULE4]
            end
        end
    end

    always_ff @(posedge ref_clk or posedge tap_arst) begin
        if (tap_arst) begin
            st_q        <= jtp_pkg::JTP_TLR;
            ir_q        <= jtp_pkg::JTP_IR_RST;
            ir_sh_q     <= jtp_pkg::JTP_IR_CAPT;
            bsr_q       <= '0;
            byp_q       <= 1'b0;
            cfg_sh_q    <= '0;
            bit_q       <= '0;
            push_q      <= 1'b0;
            push_data_q <= '0;
            tdo_q       <= 1'b0;
            oe_q        <= 1'b0;
            ones_q      <= 3'h0;
        end else if (ce) begin
            st_q        <= st_d;
            ir_q        <= ir_d;
            ir_sh_q     <= ir_sh_d;
            bsr_q       <= bsr_d;
            byp_q       <= byp_d;
            cfg_sh_q    <= cfg_sh_d;
            bit_q       <= bit_d;
            push_q      <= push_d;
            push_data_q <= push_data_d;
            tdo_q       <= tdo_d;
            oe_q        <= oe_d;
            ones_q      <= ones_d;
        end
    end

    // no backpressure to the host: a full fifo drops the byte
    jtp_fifo #(
        .W (CFG_W),
        .D (FIFO_D)
    ) jtp_fifo_inst (
        .ref_clk   (ref_clk),
        .rst       (tap_arst),
        .ce        (ce),
        .in_valid  (push_q),
        .in_ready  (),
        .in_data   (push_data_q),
        .out_valid (f_valid),
        .out_ready (out_rdy),
        .out_data  (f_data)
    );

    assign out_rdy = ~cv_q | cfg_ready;

    always_comb begin
        io_oe_d    = ~act & oe_s; // [RULE7]
        clr_n_d    = clr_s;
        abort_d    = act & passive_serial_busy; // [RULE9]
        complete_d = complete_q;
        err_n_d    = err_n_q;
        cv_d       = cv_q;
        cd_d       = cd_q;
        // set wins over the clear of a new download
        if (act && cfg_load_done && err_n_q) begin
            complete_d = 1'b1; // [RULE14]
        end else if (start) begin
            complete_d = 1'b0;
        end
        if (act && cfg_load_err) begin
            err_n_d = 1'b0; // [RULE13]
        end else if (start) begin
            err_n_d = 1'b1;
        end
        if (out_rdy) begin
            cv_d = f_valid;
            if (f_valid) begin
                cd_d = f_data;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge tap_arst) begin
        if (tap_arst) begin
            io_oe_q    <= 1'b0;
            clr_n_q    <= 1'b1;
            abort_q    <= 1'b0;
            complete_q <= 1'b0;
            err_n_q    <= 1'b1;
            cv_q       <= 1'b0;
            cd_q       <= '0;
        end else if (ce) begin
            io_oe_q    <= io_oe_d;
            clr_n_q    <= clr_n_d;
            abort_q    <= abort_d;
            complete_q <= complete_d;
            err_n_q    <= err_n_d;
            cv_q       <= cv_d;
            cd_q       <= cd_d;
        end
    end

    assign tdo_o                 = tdo_q;
    assign tdo_oe                = oe_q;
    assign user_io_oe            = io_oe_q;
    assign user_clear_n          = clr_n_q;
    assign passive_serial_abort  = abort_q;
    assign cfg_valid             = cv_q;
    assign cfg_data              = cd_q;
    assign config_complete       = complete_q;
    assign config_error_status_n = err_n_q;

    chk_oe_off_idle: assert property (@(posedge ref_clk) // [RULE4]
        disable iff (tap_arst)
        (ce && tck_fall && st_q != jtp_pkg::JTP_SHDR
            && st_q != jtp_pkg::JTP_SHIR) |=> !oe_q)
        else $error("tdo driven outside a shift state");
    chk_tdo_fall_only: assert property (@(posedge ref_clk) // [RULE3]
        disable iff (tap_arst)
        (!(ce && tck_fall)) |=> $stable(tdo_q))
        else $error("tdo moved without a falling tck");
    chk_tlr_five_ones: assert property (@(posedge ref_clk) // [RULE16]
        disable iff (tap_arst)
        (ones_q == 3'(jtp_pkg::JTP_TLR_TMS)) |-> (st_q == jtp_pkg::JTP_TLR))
        else $error("five tms-high edges did not reach reset");
    chk_bypass_one_bit: assert property (@(posedge ref_clk) // [RULE12]
        disable iff (tap_arst)
        (ce && tck_rise && st_q == jtp_pkg::JTP_SHDR) |=> (byp_q == $past(tdi_s)))
        else $error("bypass bit did not take tdi");
    chk_io_released: assert property (@(posedge ref_clk) // [RULE7]
        disable iff (tap_arst)
        (ce && act) |=> !io_oe_q)
        else $error("user pins driven during download");
    chk_ps_abort: assert property (@(posedge ref_clk) // [RULE9]
        disable iff (tap_arst)
        (ce && act && passive_serial_busy) |=> abort_q)
        else $error("passive serial load not aborted");
    chk_err_low: assert property (@(posedge ref_clk) // [RULE13]
        disable iff (tap_arst)
        (ce && act && cfg_load_err) |=> !err_n_q)
        else $error("error status not pulled low");
    chk_done_high: assert property (@(posedge ref_clk) // [RULE14]
        disable iff (tap_arst)
        (ce && act && cfg_load_done && err_n_q) |=> complete_q)
        else $error("complete not raised after a good download");

    cov_bypass_shift: cover property (@(posedge ref_clk)
        st_q == jtp_pkg::JTP_SHDR && ir_q == jtp_pkg::JTP_IR_BYPASS);
    cov_cfg_push: cover property (@(posedge ref_clk) push_q);
    cov_cfg_done: cover property (@(posedge ref_clk) $rose(complete_q));
endmodule : jtp_tap

// file: verif/jtp_cable.sv
// cable model: drives the port pins, tck only inside frames
`timescale 1ns/10ps
module jtp_cable (
    // test port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo_o
);
    initial begin
        {tck, tms, tdi, trst_n} = 4'h7;
    end
    // tdo is read just before the rise, as a host would
    task automatic step(input logic m, d, output logic o);
        tms = m;
        tdi = d;
        #12 o = tdo_o;
        tck = 1'b1;
        #24 tck = 1'b0;
        #12;
    endtask : step
endmodule : jtp_cable

// file: verif/jtag_config_tap_port_test.sv
// bench for jtp_tap: bypass, reset, download
`timescale 1ns/10ps
module jtag_config_tap_port_test;
    logic ref_clk = 0, rst = 1, ps = 0, cw = 1, o;
    logic tck, tms, tdi, trst_n, tdo_o, tdo_oe, io_oe;
    logic dn = 0, er = 0, rd = 0, abt, cv, cc, en;
    logic [7:0] cd;
    int   failures = 0, n_compared = 0;
    initial forever #2 ref_clk = ~ref_clk;
    jtp_cable jtp_cable_inst (.tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo_o(tdo_oe ? tdo_o : ~tdo_o));
    jtp_tap jtp_tap_inst (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe), .user_pin_in(8'hA5),
        .chip_wide_clear(cw), .chip_wide_output_enable(cw),
        .user_io_oe(io_oe), .user_clear_n(), .passive_serial_busy(ps),
        .cfg_load_done(dn), .cfg_load_err(er),
        .passive_serial_abort(abt), .cfg_valid(cv), .cfg_ready(rd),
        .cfg_data(cd), .config_complete(cc), .config_error_status_n(en));
    task automatic chk(string n, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %b got %b", n, e, g);
        end
    endtask : chk
    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk8
    // tms bits lsb first, tdi held high
    task automatic walk(logic [15:0] m, int n);
        for (int i = 0; i < n; i++) jtp_cable_inst.step(m[i], 1'b1, o);
        repeat (8) @(negedge ref_clk);
    endtask : walk
    task automatic load_ir(logic [3:0] ir);
        walk(16'h00DF, 10);
        for (int i = 0; i < 4; i++) jtp_cable_inst.step(i == 3, ir[i], o);
        walk(16'h0005, 5);
    endtask : load_ir
    task automatic t_bypass();
        logic [7:0] d = 8'hB4;
        logic       p = 1'b0;
        walk(16'h001F, 5);
        chk("tdo_oe", 1'b0, tdo_oe);
        chk("user_io_oe", 1'b1, io_oe);
        load_ir(jtp_pkg::JTP_IR_BYPASS);
        for (int i = 0; i < 8; i++) begin
            cw = ~cw; // chip-wide pins must not disturb the shift
            jtp_cable_inst.step(1'b0, d[i], o);
            chk("tdo", p, o);
            chk("tdo_oe", 1'b1, tdo_oe);
            p = d[i];
        end
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_trst();
        jtp_cable_inst.trst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk("tdo_oe", 1'b0, tdo_oe);
        jtp_cable_inst.trst_n = 1'b1;
        $display("trst test done");
    endtask : t_trst
    task automatic t_sample();
        logic [7:0] v = 8'hA5;
        load_ir(jtp_pkg::JTP_IR_SAMPLE);
        for (int i = 0; i < 8; i++) begin
            jtp_cable_inst.step(1'b0, 1'b0, o);
            chk("bsr", v[i], o);
        end
        $display("sample test done");
    endtask : t_sample
    task automatic t_config();
        logic [7:0] d = 8'h3C;
        ps = 1'b1; // a passive_serial load is running
        load_ir(jtp_pkg::JTP_IR_CONFIG);
        chk("user_io_oe", 1'b0, io_oe);
        chk("passive_serial_abort", 1'b1, abt);
        ps = 1'b0;
        for (int i = 0; i < 8; i++) jtp_cable_inst.step(1'b0, d[i], o);
        repeat (8) @(negedge ref_clk);
        chk("cfg_valid", 1'b1, cv);
        chk8("cfg_data", d, cd);
        er = 1'b1;
        repeat (4) @(negedge ref_clk);
        er = 1'b0;
        chk("config_error_status_n", 1'b0, en);
        dn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("config_complete", 1'b0, cc);
        dn = 1'b0;
        walk(16'h001F, 5);
        load_ir(jtp_pkg::JTP_IR_CONFIG);
        chk("config_error_status_n", 1'b1, en);
        dn = 1'b1;
        repeat (4) @(negedge ref_clk);
        dn = 1'b0;
        chk("config_complete", 1'b1, cc);
        chk("user_io_oe", 1'b1, io_oe);
        $display("config test done");
    endtask : t_config
    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        t_bypass();
        t_trst();
        t_sample();
        t_config();
        report_and_stop();
    end
    initial begin
        #20000 failures++;
        report_and_stop();
    end
endmodule : jtag_config_tap_port_test
